//--- flash_sector_program_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_sector_program_sequencer_tb;
    logic ref_clk = 0, rst_n = 0, progStart = 0, readReq = 0;
    logic [10:0] progSector = 0;
    logic [18:0] readAddr = 0;
    logic [7:0] wrData = 0, dat [256], q [$];
    logic [15:0] lf = 16'd35667;
    wire logic wrReady, busy, readValid, progDone, progTimeout, dataOutEn;
    wire logic [7:0] wrIndex, readData, dataOut, dataIn;
    wire fsp_pkg::fsp_bus_s flashBus;
    int n_mismatch = 0, num_checks = 0, cyc = 0, nDone = 0, nReady = 0, nProg = 0;
    // ----------------
    // Clock, design, device model
    // ----------------
    always #2.5 ref_clk = ~ref_clk;
    fsp_host #(.POLL_LIMIT(2000)) u_dut (.ref_clk, .rst_n, .progStart, .progSector, .readReq,
        .readAddr, .wrReady, .wrData, .wrIndex, .busy, .readValid, .readData, .progDone,
        .progTimeout, .flashBus, .dataOut, .dataOutEn, .dataIn);
    fsp_flash_model #(.TWC(800)) u_mem (.ref_clk, .bus(flashBus), .dIo(dataOut),
        .dq(dataIn));
    always @(posedge ref_clk) #1 wrData <= dat[wrIndex];
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic idle();
        @(posedge ref_clk) #1;
        for (int i = 0; i < 70000 && busy !== 1'b0; i++) @(posedge ref_clk) #1;
    endtask
    task automatic rd(input logic [18:0] a, input logic [7:0] e);
        q.push_back(e);
        readAddr = a;
        readReq = 1;
        @(posedge ref_clk) #1 readReq = 0;
        idle();
    endtask
    task automatic prog(input logic [10:0] s);
        for (int i = 0; i < 256; i++) begin
            lf = nx(lf);
            dat[i] = lf[7:0];
        end
        progSector = s;
        progStart = 1;
        @(posedge ref_clk) #1 progStart = 0;
        idle();
        nProg++;
        num_checks++;
        if (nDone !== nProg || nReady !== 256 * nProg || progTimeout !== 1'b0) begin
            n_mismatch++;
            $display("[FAIL] t=%0t done=%h exp=%h ready=%h", $time, nDone, nProg, nReady);
        end
        for (int i = 0; i < 256; i += 37) rd({i[7:4], s, i[3:0]}, dat[i]);
        rd({4'hf, s, 4'hf}, dat[255]);
        rd({4'h0, s + 11'h1, 4'h0}, {s[3:0] + 4'h1, 4'h0} ^ 8'h5a);
        $display("sector %h done", s);
    endtask
    always @(negedge ref_clk) if (readValid === 1'b1) begin
        num_checks++;
        if (q.size() == 0 || readData !== q[0]) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, readData, q.size() ? q[0] : 8'h00);
        end
        if (q.size()) void'(q.pop_front());
    end
    always @(negedge ref_clk) begin
        if (progDone === 1'b1) nDone++;
        if (wrReady === 1'b1) nReady++;
    end
    always @(posedge ref_clk) if (++cyc == 100000) begin
        n_mismatch++;
        give_verdict();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        #1 rst_n = 1;
        @(posedge ref_clk) #1;
        for (int i = 0; i < 8; i++) begin
            lf = nx(lf);
            rd({lf[2:0], lf}, lf[7:0] ^ 8'h5a);
        end
        $display("reads done");
        prog(11'h000);
        prog(11'h7fe);
        repeat (30) @(posedge ref_clk);
        num_checks++;
        if (q.size() != 0) begin
            n_mismatch++;
            $display("[FAIL] t=%0t left=%h exp=%h", $time, q.size(), 0);
        end
        give_verdict();
    end
endmodule
`default_nettype wire

//--- fsp_defines.svh
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define FSP_ADDR_W          19
`define FSP_SECTOR_BYTES    9'h100
`define FSP_SECTOR_LSB      4
`define FSP_SECTOR_MSB      14

// ----------------------------------------
// Unlock sequence (arbitrary defaults, parameters in the top)
// ----------------------------------------
`define FSP_UNL_ADDR0       19'h05555
`define FSP_UNL_ADDR1       19'h02aaa
`define FSP_UNL_ADDR2       19'h05555
`define FSP_UNL_DATA0       8'haa
`define FSP_UNL_DATA1       8'h55
`define FSP_UNL_DATA2       8'ha0

// ----------------------------------------
// Timing
// ----------------------------------------
`define FSP_CLK_NS          5
`define FSP_LOAD_GAP_NS     150000
`define FSP_STROBE_MIN_NS   30
`define FSP_SETUP_NS        30
`define FSP_GAP_MAX_CYC     (`FSP_LOAD_GAP_NS / `FSP_CLK_NS)
`define FSP_LOAD_GAP_CYC    ((`FSP_GAP_MAX_CYC) / 2)
`define FSP_STROBE_CYC      ((`FSP_STROBE_MIN_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_SETUP_CYC       ((`FSP_SETUP_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_CLOSE_CYC       (`FSP_GAP_MAX_CYC + 16)
`define FSP_POLL_MAX        24'h1e8480

`endif

//--- fsp_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defines.svh"
module fsp_flash_model #(
    parameter int GAP = `FSP_GAP_MAX_CYC,
    parameter int TWC = 2000000,
    parameter int PUP = 100
) (
    input wire logic              ref_clk,
    input wire fsp_pkg::fsp_bus_s bus,
    input wire logic [7:0]        dIo,
    output logic [7:0]            dq
);
    // ----------------
    // Behavioural array sampled on the host clock
    // ----------------
    logic [7:0]  mem [logic [18:0]];
    logic [7:0]  ld [logic [18:0]];
    logic [18:0] ua [3] = '{`FSP_UNL_ADDR0, `FSP_UNL_ADDR1, `FSP_UNL_ADDR2};
    logic [7:0]  ud [3] = '{`FSP_UNL_DATA0, `FSP_UNL_DATA1, `FSP_UNL_DATA2};
    logic        pWe = 1'b1;
    logic [18:0] la = '0;
    logic [7:0]  lastD = '0;
    int          unl = 0;
    int          pup = PUP;
    int          gap = 0;
    int          twc = 0;
    wire wr = !bus.flashSelN && bus.eepromSelN && bus.readDriveN && (pup == 0);
    wire rd = !bus.flashSelN && bus.eepromSelN && !bus.readDriveN && bus.writeStrobeN;
    function automatic logic [7:0] get(input logic [18:0] a);
        return mem.exists(a) ? mem[a] : a[7:0] ^ 8'h5a;
    endfunction
    initial dq = 8'h00;
    // Released lines toggle so a stale value can never pass for data
    always @(posedge ref_clk) begin
        pWe <= bus.writeStrobeN;
        dq <= !rd ? ~dq : twc > 0 ? {~lastD[7], lastD[6:0]} : get(bus.addr);
        if (twc > 0) twc <= twc - 1;
        if (pup > 0) pup <= pup - 1;
        if (wr && pWe && !bus.writeStrobeN) la <= bus.addr;
        if (wr && !pWe && bus.writeStrobeN) begin
            if (unl == 3) begin
                ld[la] = dIo;
                lastD <= dIo;
                gap <= GAP;
            end else if (la == ua[unl] && dIo == ud[unl]) unl <= unl + 1;
            else begin
                unl <= 0;
                twc <= TWC;
            end
        end else if (gap == 1) begin
            for (int i = 0; i < 256; i++) mem[{i[7:4], la[14:4], i[3:0]}] = 8'hff;
            foreach (ld[a]) mem[a] = ld[a];
            ld.delete();
            unl <= 0;
            twc <= TWC;
            gap <= 0;
        end else if (gap > 0) gap <= gap - 1;
    end
endmodule
`default_nettype wire

//--- fsp_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defines.svh"
// Functional notes
// - Host opens every program operation with the three-write unlock.
// - Host loads bytes by write strobe pulses, read and EEPROM select high.
// - Host loads all 256 sector bytes even to change one.
// - Host starts each next load within 150 us of previous rise.
// - Host may load bytes in any order, sector address stable.
// - Host never drives flash and EEPROM selects low together.

module fsp_host #(
    parameter logic [18:0] UNL_ADDR0   = `FSP_UNL_ADDR0,
    parameter logic [18:0] UNL_ADDR1   = `FSP_UNL_ADDR1,
    parameter logic [18:0] UNL_ADDR2   = `FSP_UNL_ADDR2,
    parameter logic [7:0]  UNL_DATA0   = `FSP_UNL_DATA0,
    parameter logic [7:0]  UNL_DATA1   = `FSP_UNL_DATA1,
    parameter logic [7:0]  UNL_DATA2   = `FSP_UNL_DATA2,
    parameter int          POLL_LIMIT  = `FSP_POLL_MAX
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              progStart,
    input  wire logic [10:0]       progSector,
    input  wire logic              readReq,
    input  wire logic [18:0]       readAddr,
    output logic                   wrReady,
    input  wire logic [7:0]        wrData,
    output logic [7:0]             wrIndex,
    output logic                   busy,
    output logic                   readValid,
    output logic [7:0]             readData,
    output logic                   progDone,
    output logic                   progTimeout,
    output fsp_pkg::fsp_bus_s      flashBus,
    output logic [7:0]             dataOut,
    output logic                   dataOutEn,
    input  wire logic [7:0]        dataIn
);

    // ----------------------------------------
    // Datapath state
    // ----------------------------------------
    fsp_pkg::fsp_state_e state;
    fsp_pkg::fsp_state_e next_state;
    fsp_pkg::fsp_cmd_s   cmd;
    logic [8:0]          step;
    logic [23:0]         timer;
    logic [7:0]          lastData;
    logic                inProg;
    logic [10:0]         sector;
    logic [23:0]         pollCount;

    // Steps 0..2 are unlock writes, 3..258 are sector loads
    wire         isUnlock  = (step < 9'h003);
    wire [7:0]   byteIdx   = 8'(step - 9'h003);
    wire         lastLoad  = (step == 9'h102);
    // byte index spread over bits 0..3 and 15..18, sector held fixed
    wire [18:0]  loadAddr  = {byteIdx[7:4], sector, byteIdx[3:0]};
    wire [18:0]  unlAddr   = (step == 9'h000) ? UNL_ADDR0 :
                             (step == 9'h001) ? UNL_ADDR1 : UNL_ADDR2;
    wire [7:0]   unlData   = (step == 9'h000) ? UNL_DATA0 :
                             (step == 9'h001) ? UNL_DATA1 : UNL_DATA2;
    wire         pollDone  = (dataIn[7] == lastData[7]);
    wire         timerHit  = (timer == 24'h000000);
    wire         pollOver  = (pollCount >= 24'(POLL_LIMIT));
    // Taken one cycle before setup ends so the address settles ahead of the strobe fall
    wire         loadPoint = (state == fsp_pkg::FSP_SETUP) && (timer == 24'h000001);
    wire         pollRead  = cmd.isRead && inProg;
    wire         startProg = (state == fsp_pkg::FSP_IDLE) && progStart;
    wire         giveUp    = (state == fsp_pkg::FSP_HOLD) && pollRead && !pollDone && pollOver;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            fsp_pkg::FSP_IDLE: begin
                if (progStart || readReq) begin
                    next_state = fsp_pkg::FSP_SETUP;
                end
            end
            fsp_pkg::FSP_SETUP: begin
                if (timerHit) begin
                    next_state = fsp_pkg::FSP_STROBE;
                end
            end
            fsp_pkg::FSP_STROBE: begin
                if (timerHit) begin
                    next_state = fsp_pkg::FSP_HOLD;
                end
            end
            fsp_pkg::FSP_HOLD: begin
                if (pollRead) begin
                    // Stop once bit 7 matches bit 7 of the last loaded byte, or give up at the limit
                    if (pollDone || pollOver) begin
                        next_state = fsp_pkg::FSP_DONE;
                    end else begin
                        next_state = fsp_pkg::FSP_SETUP;
                    end
                end else if (cmd.isRead) begin
                    next_state = fsp_pkg::FSP_DONE;
                end else if (lastLoad) begin
                    next_state = fsp_pkg::FSP_POLL;
                end else begin
                    next_state = fsp_pkg::FSP_SETUP;
                end
            end
            fsp_pkg::FSP_POLL: begin
                if (timerHit) begin
                    next_state = fsp_pkg::FSP_SETUP;
                end
            end
            default: begin
                next_state = fsp_pkg::FSP_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= fsp_pkg::FSP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // Counters and command capture
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cmd      <= '0;
            step     <= 9'h000;
            timer    <= 24'h000000;
            lastData <= 8'h00;
            inProg   <= 1'b0;
            sector   <= 11'h000;
            pollCount <= 24'h000000;
        end else begin
            case (state)
                fsp_pkg::FSP_IDLE: begin
                    timer <= 24'(`FSP_SETUP_CYC);
                    step  <= 9'h000;
                    pollCount <= 24'h000000;
                    if (progStart) begin
                        cmd.isRead <= 1'b0;
                        sector     <= progSector;
                        inProg     <= 1'b1;
                    end else if (readReq) begin
                        cmd.isRead <= 1'b1;
                        cmd.addr   <= readAddr;
                    end
                end
                fsp_pkg::FSP_SETUP: begin
                    timer <= timerHit ? 24'(`FSP_STROBE_CYC) : timer - 24'h000001;
                    if (loadPoint && !cmd.isRead) begin
                        cmd.addr <= isUnlock ? unlAddr : loadAddr;
                        cmd.data <= isUnlock ? unlData : wrData;
                    end
                end
                fsp_pkg::FSP_STROBE: begin
                    timer <= timerHit ? 24'h000000 : timer - 24'h000001;
                    if (!cmd.isRead && !isUnlock) begin
                        lastData <= cmd.data;
                    end
                end
                fsp_pkg::FSP_HOLD: begin
                    if (!cmd.isRead) begin
                        step <= step + 9'h001;
                    end
                    if (pollRead) begin
                        pollCount <= pollCount + 24'h000001;
                    end
                    if (lastLoad && !cmd.isRead) begin
                        timer <= 24'(`FSP_CLOSE_CYC);
                    end else begin
                        timer <= 24'(`FSP_SETUP_CYC);
                    end
                end
                fsp_pkg::FSP_POLL: begin
                    // Polling before the load window closes would read stale array data
                    timer <= timerHit ? 24'(`FSP_SETUP_CYC) : timer - 24'h000001;
                    if (timerHit) begin
                        cmd.isRead <= 1'b1;
                    end
                end
                default: begin
                    inProg <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    wire strobeLow = (state == fsp_pkg::FSP_STROBE);
    // EEPROM select never asserted by this host
    // writes keep read drive high, reads keep write strobe high
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flashBus  <= '{flashSelN: 1'b1, eepromSelN: 1'b1, readDriveN: 1'b1,
                           writeStrobeN: 1'b1, addr: 19'h00000};
            dataOut   <= 8'h00;
            dataOutEn <= 1'b0;
        end else begin
            flashBus.eepromSelN   <= 1'b1;
            flashBus.flashSelN    <= (state == fsp_pkg::FSP_IDLE) ||
                                     (state == fsp_pkg::FSP_DONE) ||
                                     (state == fsp_pkg::FSP_POLL);
            flashBus.writeStrobeN <= !(strobeLow && !cmd.isRead);
            flashBus.readDriveN   <= !(strobeLow && cmd.isRead);
            flashBus.addr         <= cmd.addr;
            dataOut               <= cmd.data;
            dataOutEn             <= !cmd.isRead && (state != fsp_pkg::FSP_IDLE) &&
                                     (state != fsp_pkg::FSP_POLL);
        end
    end

    // ----------------------------------------
    // User side
    // ----------------------------------------
    // loads follow each other by a few cycles, far inside 150 us
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wrReady     <= 1'b0;
            wrIndex     <= 8'h00;
            busy        <= 1'b0;
            readValid   <= 1'b0;
            readData    <= 8'h00;
            progDone    <= 1'b0;
            progTimeout <= 1'b0;
        end else begin
            // user supplies all 256 bytes, one per sector load setup phase
            wrReady   <= loadPoint && !cmd.isRead && !isUnlock;
            wrIndex   <= byteIdx;
            busy      <= (state != fsp_pkg::FSP_IDLE);
            readValid <= (state == fsp_pkg::FSP_HOLD) && cmd.isRead && !inProg;
            readData  <= dataIn;
            progDone  <= (state == fsp_pkg::FSP_DONE) && inProg;
            progTimeout <= giveUp || (progTimeout && !startProg);
        end
    end

endmodule
`default_nettype wire

//--- fsp_host_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module fsp_host_monitor (
    input wire logic              ref_clk,
    input wire logic              rst_n,
    input wire fsp_pkg::fsp_bus_s flashBus,
    input wire logic [7:0]        dataOut,
    input wire logic              dataOutEn,
    input wire logic              busy
);
    // ----------------
    // Bus discipline of the host
    // ----------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_eeprom_off: assert property (flashBus.eepromSelN)
        else $error("eeprom select low");
    a_load_mode: assert property (!flashBus.writeStrobeN |-> flashBus.readDriveN && !flashBus.flashSelN)
        else $error("bad load mode");
    a_load_drives: assert property (!flashBus.writeStrobeN |-> dataOutEn)
        else $error("load without data drive");
    a_read_free: assert property (!flashBus.readDriveN |-> !dataOutEn)
        else $error("contention on read");
    a_strobe_width: assert property ($fell(flashBus.writeStrobeN) |-> (!flashBus.writeStrobeN)[*3])
        else $error("strobe too short");
    a_addr_setup: assert property ($fell(flashBus.writeStrobeN) |-> $stable(flashBus.addr))
        else $error("address moved at fall");
    a_addr_hold: assert property (!flashBus.writeStrobeN && $past(!flashBus.writeStrobeN) |-> $stable(flashBus.addr))
        else $error("address moved in load");
    a_data_hold: assert property (!flashBus.writeStrobeN && $past(!flashBus.writeStrobeN) |-> $stable(dataOut))
        else $error("data moved in load");
    a_idle_quiet: assert property (!busy |-> flashBus.writeStrobeN)
        else $error("strobe while idle");
endmodule
bind fsp_host fsp_host_monitor u_mon (.ref_clk, .rst_n, .flashBus, .dataOut, .dataOutEn, .busy);
`default_nettype wire

//--- fsp_pkg.sv
package fsp_pkg;

    typedef enum logic [2:0] {
        FSP_IDLE   = 3'b000,
        FSP_SETUP  = 3'b001,
        FSP_STROBE = 3'b011,
        FSP_HOLD   = 3'b010,
        FSP_POLL   = 3'b110,
        FSP_DONE   = 3'b111
    } fsp_state_e;

    typedef struct packed {
        logic        flashSelN;
        logic        eepromSelN;
        logic        readDriveN;
        logic        writeStrobeN;
        logic [18:0] addr;
    } fsp_bus_s;

    typedef struct packed {
        logic        isRead;
        logic [18:0] addr;
        logic [7:0]  data;
    } fsp_cmd_s;

endpackage
